// file: src/asrc_pkg.sv
// constants, field layouts and encodings of the serial port control block
// assumes a single mclk domain; pins are synchronised before use
// How it works
// - reset holds state, outputs released
// - after reset: clear buffer, raise settle flag
// - mute counter starts at full attenuation
// - twelve-bit mute counter, one step per frame
// - mute request ramps down over 4095 frames
// - release ramps back up over 4095 frames
// - settle flag: reset/rate change until slow mode
// - input format select decode table
// - output format select decode table
// - output word width select decode table
// - dither truncated bits unless bypass
// - right-justified output: 64 bit clocks per frame
// - TDM: 64-bit shifter, chain in, data out
// - master TDM chain is four devices
// - never both ports clock master
// - master divides mclk by 256/512/768
// - clock mode select decode table
// - bypass passes input truncated to width, no dither
package asrc_pkg;
  localparam int WORD_W  = 24;
  localparam int SLOT_W  = 32;
  localparam int FRAME_W = 64;
  localparam int MUTE_W  = 12;
  localparam int PER_W   = 16;
  localparam int ADDR_W  = 4;
  localparam int CTRL_W  = 12;
  localparam int BUF_DEPTH = 512;
  localparam int TDM_DEVICES = 4;
  // register map and fields
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  localparam int F_INFMT = 0;
  localparam int F_OUTFMT = 3;
  localparam int F_WIDTH = 5;
  localparam int F_CLKMODE = 7;
  localparam int F_BYPASS = 10;
  localparam int F_MUTE = 11;
  // mute ramp
  localparam logic [MUTE_W-1:0] MUTE_MAX = 12'hfff;
  localparam logic [MUTE_W:0] GAIN_UNITY = 13'h1000;
  // encodings
  localparam logic [2:0] IN_I2S = 3'h1;
  localparam logic [2:0] CLK_UNDEF = 3'h4;
  localparam logic [1:0] RATIO_768 = 2'h1;
  localparam logic [1:0] RATIO_512 = 2'h2;
  typedef enum logic [1:0] {OUT_LJ, OUT_I2S, OUT_TDM, OUT_RJ} out_fmt_t;
  typedef enum logic {ST_CLEAR, ST_RUN} init_state_t;
  // bits dropped per width code, and left pad per input RJ code
  localparam logic [3:0] OUT_TRUNC [4] = '{4'h0, 4'h4, 4'h6, 4'h8};
  localparam logic [3:0] IN_PAD [4] = '{4'h8, 4'h6, 4'h4, 4'h0};
  // last bit index of a left-justified / I2S word
  localparam logic [5:0] LJ_LAST  = 6'h17;
  localparam logic [5:0] I2S_LAST = 6'h18;
  // master divider half periods in mclk cycles
  localparam logic [3:0] HALF_768 = 4'h6;
  localparam logic [3:0] HALF_512 = 4'h4;
  localparam logic [3:0] HALF_256 = 4'h2;
  localparam logic [3:0] HALF_TDM = 4'h1;
  localparam logic [7:0] LAST_STD = 8'(FRAME_W - 1);
  localparam logic [7:0] LAST_TDM = 8'(TDM_DEVICES * FRAME_W - 1);
  // rate change tolerance in mclk cycles, dither generator
  localparam logic [PER_W-1:0] RATE_TOL = 16'h0002;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
endpackage

// file: src/pin_sync.sv
// two-stage synchroniser for pins arriving from outside the mclk domain
// assumes the pins are slow next to mclk
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // clock and control
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // raw pins and their synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else if (ce)
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// file: src/mute_ramp.sv
// soft mute: counter of attenuation steps and the linear gain stage
// assumes tick is one cycle per input frame and inValid one per pair
`timescale 1ns/1ps
`default_nettype none
module mute_ramp
  import asrc_pkg::*;
(
  // clock and control
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                tick,
  input  wire logic                muteReq,
  // samples in and scaled samples out
  input  wire logic                inValid,
  input  wire logic [WORD_W-1:0]   inLeft,
  input  wire logic [WORD_W-1:0]   inRight,
  output logic      [WORD_W-1:0]   outLeft,
  output logic      [WORD_W-1:0]   outRight,
  output logic                     outValid,
  output logic      [MUTE_W-1:0]   level
);
  import asrc_pkg::*;
  // full count gives zero gain, the floor of the ramp
  wire logic [MUTE_W:0] gain = (level == '0) ? GAIN_UNITY : {1'b0, MUTE_MAX - level};
  logic [WORD_W-1:0] held [2];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      level <= MUTE_MAX;
    else if (ce && tick)
    begin
      if (muteReq && level != MUTE_MAX)
        level <= level + 12'h001;
      else if (!muteReq && level != '0)
        level <= level - 12'h001;
    end
  end

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    wire logic [WORD_W-1:0] src = (ch == 0) ? inLeft : inRight;
    wire logic signed [WORD_W+MUTE_W+1:0] prod = $signed(src) * $signed({1'b0, gain});
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        held[ch] <= '0;
      else if (ce && inValid)
        held[ch] <= prod[WORD_W+MUTE_W-1:MUTE_W];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      outValid <= 1'b0;
    else if (ce)
      outValid <= inValid;
  end

  assign outLeft  = held[0];
  assign outRight = held[1];
endmodule
`default_nettype wire

// file: src/asrc_serial_port_control.sv
// serial port control of the rate converter: registers, clock modes,
// input deserialiser, soft mute, settle flag, dither and output shifter
// assumes the convolution result arrives on srcLeft/srcRight in mclk
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asrc_serial_port_control
  import asrc_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  // clock, reset, clock enable
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // register port
  input  wire logic [ADDR_W-1:0]        addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [31:0]              rdata,
  // input serial port pins
  input  wire logic                     rxSclkPin,
  output logic                          rxSclkDrive,
  output logic                          rxClkOe,
  input  wire logic                     rxLrPin,
  output logic                          rxLrDrive,
  input  wire logic                     rxSdataPin,
  // output serial port pins
  input  wire logic                     txSclkPin,
  output logic                          txSclkDrive,
  output logic                          txClkOe,
  input  wire logic                     txLrPin,
  output logic                          txLrDrive,
  input  wire logic                     tdmInPin,
  output logic                          output_serial_data,
  output logic                          muteOut,
  output logic                          outPinsOe,
  // converter datapath
  input  wire logic                     servoFast,
  input  wire logic [WORD_W-1:0]        srcLeft,
  input  wire logic [WORD_W-1:0]        srcRight,
  output logic      [WORD_W-1:0]        attenLeft,
  output logic      [WORD_W-1:0]        attenRight,
  output logic                          attenValid,
  output logic      [$clog2(DEPTH)-1:0] bufClrAddr,
  output logic                          bufClrWe
);
  import asrc_pkg::*;

  function automatic logic [WORD_W-1:0] shape(input logic [WORD_W-1:0] w,
    input logic [3:0] tr, input logic on, input logic [7:0] noise);
    logic [WORD_W-1:0] keep;
    logic [WORD_W:0]   sum;
    keep = ~((24'h000001 << tr) - 24'h000001);
    sum = {w[WORD_W-1], w} + {17'h00000, on ? (noise & ~keep[7:0]) : 8'h00};
    // saturate rather than wrap when the noise overflows full scale
    if (sum[WORD_W] != sum[WORD_W-1])
      sum[WORD_W-1:0] = sum[WORD_W] ? 24'h800000 : 24'h7fffff;
    return sum[WORD_W-1:0] & keep;
  endfunction

  function automatic logic [SLOT_W-1:0] place(input logic [WORD_W-1:0] w,
    input logic [1:0] fmt, input logic [3:0] tr);
    if (fmt == OUT_I2S)
      return {1'b0, w, 7'h00};
    if (fmt == OUT_RJ)
      return {8'h00, w} >> tr;
    return {w, 8'h00};
  endfunction

  logic [CTRL_W-1:0] ctrl;
  init_state_t       state;
  logic              settle;
  logic              seenFast;
  logic [MUTE_W-1:0] muteCnt;
  logic [5:0]        pinS;
  logic              genSclk;
  logic              genLr;
  logic [3:0]        divCnt;
  logic [7:0]        genBit;
  logic              rxSclkQ;
  logic              rxLrQ;
  logic              txSclkQ;
  logic              txLrQ;
  logic [SLOT_W-1:0] rxShift;
  logic [5:0]        rxCnt;
  logic              rxLeftHalf;
  logic [WORD_W-1:0] rxLeft;
  logic [WORD_W-1:0] rxRight;
  logic              rxPair;
  logic [FRAME_W-1:0] txShift;
  logic [15:0]       noise;

  wire logic [2:0] inFmt   = ctrl[F_INFMT +: 3];
  wire logic [1:0] outFmt  = ctrl[F_OUTFMT +: 2];
  wire logic [1:0] width   = ctrl[F_WIDTH +: 2];
  wire logic [2:0] clkMode = ctrl[F_CLKMODE +: 3];
  wire logic       bypass  = ctrl[F_BYPASS];
  wire logic       muteReq = ctrl[F_MUTE];
  wire logic       inUndef = inFmt[2:1] == 2'b01;
  wire logic       clkUndef = clkMode == CLK_UNDEF;
  wire logic txMaster = ~clkMode[2] & |clkMode[1:0];
  wire logic rxMaster = clkMode[2] & |clkMode[1:0];
  wire logic anyMaster = txMaster | rxMaster;
  wire logic initBusy = state == ST_CLEAR;

  pin_sync #(.W(6)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({tdmInPin, txLrPin, txSclkPin, rxSdataPin, rxLrPin, rxSclkPin}),
    .q     (pinS)
  );

  // register port
  wire logic wrCtrl = wr && addr == ADDR_CTRL;
  wire logic [31:0] statWord = {16'h0000, clkUndef, inUndef, muteCnt, initBusy, settle};
  wire logic [31:0] readMux = (addr == ADDR_CTRL) ? {20'h00000, ctrl} :
                              (addr == ADDR_STAT) ? statWord : 32'h00000000;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl  <= CTRL_RESET;
      rdata <= '0;
    end
    else if (ce)
    begin
      if (wrCtrl)
        ctrl <= wdata[CTRL_W-1:0];
      rdata <= rd ? readMux : 32'h00000000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      outPinsOe <= 1'b0;
      rxClkOe   <= 1'b0;
      txClkOe   <= 1'b0;
    end
    else if (ce)
    begin
      outPinsOe <= 1'b1;
      rxClkOe   <= rxMaster;
      txClkOe   <= txMaster;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state      <= ST_CLEAR;
      bufClrAddr <= '0;
      bufClrWe   <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state)
        ST_CLEAR:
        begin
          bufClrWe <= 1'b1;
          if (bufClrWe)
            bufClrAddr <= bufClrAddr + 1'b1;
          if (bufClrWe && bufClrAddr == ($clog2(DEPTH))'(DEPTH - 1))
          begin
            state    <= ST_RUN;
            bufClrWe <= 1'b0;
          end
        end
        ST_RUN:
          state <= ST_RUN;
      endcase
    end
  end

  // master clock generator, shared since only one port can be master
  wire logic tdmGen = txMaster && outFmt == OUT_TDM;
  wire logic [3:0] half = tdmGen ? HALF_TDM : (clkMode[1:0] == RATIO_768) ? HALF_768 :
                          (clkMode[1:0] == RATIO_512) ? HALF_512 : HALF_256;
  // four 64-bit device frames, 256 bit clocks, per master TDM frame
  wire logic [7:0] lastBit = tdmGen ? LAST_TDM : LAST_STD;
  wire logic divWrap = divCnt == half - 4'h1;
  wire logic genFall = divWrap & genSclk;
  wire logic [7:0] next_genBit = (genBit == lastBit) ? 8'h00 : genBit + 8'h01;
  wire logic genI2s = rxMaster ? inFmt == IN_I2S : outFmt == OUT_I2S;
  wire logic next_genLr = tdmGen ? next_genBit == 8'h00 : next_genBit[5] ^ ~genI2s;

  // divide mclk down to bit and frame clocks
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !anyMaster)
    begin
      divCnt  <= '0;
      genSclk <= 1'b0;
      genBit  <= '0;
      genLr   <= 1'b0;
    end
    else if (ce)
    begin
      divCnt <= divWrap ? 4'h0 : divCnt + 4'h1;
      if (divWrap)
        genSclk <= ~genSclk;
      if (genFall)
      begin
        genBit <= next_genBit;
        genLr  <= next_genLr;
      end
    end
  end

  assign rxSclkDrive = genSclk;
  assign rxLrDrive   = genLr;
  assign txSclkDrive = genSclk;
  assign txLrDrive   = genLr;

  // port clocks as seen by the logic, own or from the pins
  wire logic rxSclk = rxMaster ? genSclk : pinS[0];
  wire logic rxLr   = rxMaster ? genLr : pinS[1];
  wire logic rxSdata = pinS[2];
  wire logic txSclk = txMaster ? genSclk : pinS[3];
  wire logic txLr   = txMaster ? genLr : pinS[4];
  wire logic tdmIn  = pinS[5];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rxSclkQ <= 1'b0;
      rxLrQ   <= 1'b0;
      txSclkQ <= 1'b0;
      txLrQ   <= 1'b0;
    end
    else if (ce)
    begin
      rxSclkQ <= rxSclk;
      rxLrQ   <= rxLr;
      txSclkQ <= txSclk;
      txLrQ   <= txLr;
    end
  end

  // input deserialiser
  wire logic rxI2s = inFmt == IN_I2S;
  wire logic rxRj = inFmt[2];
  wire logic rxRise = rxSclk & ~rxSclkQ;
  wire logic rxEdge = rxLr ^ rxLrQ;
  wire logic rxFrame = rxLr & ~rxLrQ;
  wire logic [WORD_W-1:0] rxBits = {rxShift[WORD_W-2:0], rxSdata};
  // I2S word starts one bit later
  wire logic rxTake = rxRise && !rxRj && rxCnt == (rxI2s ? I2S_LAST : LJ_LAST);
  // right-justified word ends at the frame edge
  wire logic rjTake = rxEdge && rxRj;
  wire logic [WORD_W-1:0] rjWord = rxShift[WORD_W-1:0] << IN_PAD[inFmt[1:0]];
  wire logic [WORD_W-1:0] rxWord = rjTake ? rjWord : rxBits;
  wire logic rxStore = rxTake | rjTake;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rxShift    <= '0;
      rxCnt      <= '0;
      rxLeftHalf <= 1'b0;
      rxLeft     <= '0;
      rxRight    <= '0;
      rxPair     <= 1'b0;
    end
    else if (ce)
    begin
      rxPair <= rxStore && !rxLeftHalf;
      if (rxStore && rxLeftHalf)
        rxLeft <= rxWord;
      if (rxStore && !rxLeftHalf)
        rxRight <= rxWord;
      if (rxEdge)
      begin
        rxCnt      <= '0;
        rxLeftHalf <= rxI2s ? ~rxLr : rxLr;
      end
      else if (rxRise && rxCnt != 6'h3f)
        rxCnt <= rxCnt + 6'h01;
      if (rxRise)
        rxShift <= {rxShift[SLOT_W-2:0], rxSdata};
    end
  end

  mute_ramp u_mute (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .tick     (rxFrame),
    .muteReq  (muteReq),
    .inValid  (rxPair),
    .inLeft   (rxLeft),
    .inRight  (rxRight),
    .outLeft  (attenLeft),
    .outRight (attenRight),
    .outValid (attenValid),
    .level    (muteCnt)
  );

  // sample rate watch on both frame clocks
  wire logic txFrameRise = txLr & ~txLrQ;
  wire logic [1:0] frameTick = {txFrameRise, rxFrame};
  wire logic [1:0] rateHit;

  for (genvar p = 0; p < 2; p++)
  begin : g_rate
    logic [PER_W-1:0] cnt;
    logic [PER_W-1:0] last;
    logic             seen;
    logic             hit;
    wire logic [PER_W-1:0] diff = (cnt > last) ? cnt - last : last - cnt;
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        cnt  <= '0;
        last <= '0;
        seen <= 1'b0;
        hit  <= 1'b0;
      end
      else if (ce)
      begin
        hit <= frameTick[p] && seen && diff > RATE_TOL;
        if (frameTick[p])
        begin
          last <= cnt;
          cnt  <= 16'h0001;
          seen <= 1'b1;
        end
        else if (cnt != '1)
          cnt <= cnt + 16'h0001;
      end
    end
    assign rateHit[p] = hit;
  end

  wire logic rateChange = |rateHit;

  // settle flag, set wins over release
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      settle   <= 1'b1;
      seenFast <= 1'b0;
    end
    else if (ce)
    begin
      if (initBusy || rateChange)
      begin
        settle   <= 1'b1;
        seenFast <= 1'b0;
      end
      else
      begin
        if (servoFast)
          seenFast <= 1'b1;
        if (seenFast && !servoFast)
          settle <= 1'b0;
      end
    end
  end

  assign muteOut = settle;

  // output serialiser
  wire logic tdmMode = outFmt == OUT_TDM;
  wire logic txFall = ~txSclk & txSclkQ;
  wire logic txLoad = (outFmt == OUT_I2S) ? (~txLr & txLrQ) : txFrameRise;
  wire logic [3:0] trunc = OUT_TRUNC[width];
  // dither only when truncating outside bypass
  wire logic ditherOn = trunc != 4'h0 && !bypass;
  // bypass takes the raw input pair
  wire logic [WORD_W-1:0] pickL = bypass ? rxLeft : srcLeft;
  wire logic [WORD_W-1:0] pickR = bypass ? rxRight : srcRight;
  wire logic [WORD_W-1:0] outL = shape(pickL, trunc, ditherOn, noise[7:0]);
  wire logic [WORD_W-1:0] outR = shape(pickR, trunc, ditherOn, noise[15:8]);

  // parallel load, then shift in the chain
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      txShift <= '0;
      noise   <= LFSR_SEED;
    end
    else if (ce)
    begin
      if (txLoad)
      begin
        txShift <= {place(outL, outFmt, trunc), place(outR, outFmt, trunc)};
        noise   <= noise[0] ? (noise >> 1) ^ LFSR_TAPS : noise >> 1;
      end
      else if (txFall)
        txShift <= {txShift[FRAME_W-2:0], tdmMode & tdmIn};
    end
  end

  assign output_serial_data = txShift[FRAME_W-1];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_reset_pins_off: assert property (disable iff (1'b0) !rst_n |=> !outPinsOe && !rxClkOe && !txClkOe)
    else $error("pins driven after reset");
  a_mute_preset: assert property (disable iff (1'b0) $rose(rst_n) |-> muteCnt == MUTE_MAX)
    else $error("mute counter not at full attenuation");
  a_clear_walk: assert property (ce && bufClrWe && bufClrAddr != '0 |-> $past(bufClrWe) && bufClrAddr == $past(bufClrAddr) + 1'b1)
    else $error("buffer clear skipped a word");
  a_settle_on_change: assert property (ce && rateChange |=> settle [*2])
    else $error("settle flag missed a rate change");
  a_mute_step_down: assert property (ce && rxFrame && muteReq && muteCnt != MUTE_MAX |=> muteCnt == $past(muteCnt) + 12'h001)
    else $error("mute counter did not advance");
  a_mute_step_up: assert property (ce && rxFrame && !muteReq && muteCnt != '0 |=> muteCnt == $past(muteCnt) - 12'h001)
    else $error("mute counter did not release");
  a_mute_hold: assert property (!(ce && rxFrame) |=> $stable(muteCnt))
    else $error("mute counter moved between frames");
  a_one_master: assert property (!(rxClkOe && txClkOe))
    else $error("both ports drive clocks");
  a_bypass_raw: assert property (ce && txLoad && bypass && outFmt == OUT_LJ |=> txShift[63:40] == ($past(rxLeft) & ~((24'h000001 << $past(trunc)) - 24'h000001)))
    else $error("bypass word altered");
  a_tdm_chain: assert property (ce && txFall && !txLoad && tdmMode |=> txShift[0] == $past(tdmIn))
    else $error("chain bit not shifted in");
  a_sclk_divide: assert property (ce && anyMaster && divWrap |=> genSclk != $past(genSclk))
    else $error("bit clock did not toggle at divider wrap");

  c_init_done: cover property (initBusy ##1 !initBusy);
  c_full_mute: cover property (muteReq && muteCnt == MUTE_MAX);
  c_tdm_load: cover property (ce && txLoad && tdmMode);
  c_settle_release: cover property (settle ##1 !settle);
endmodule
`default_nettype wire

// file: test/audio_source_model.sv
// serial audio port model: bit clock, frame clock and data of one port
// assumes one mclk; with run low the port stands idle
`timescale 1ns/1ps
`default_nettype none
module audio_source_model #(
  parameter int HALF = 4
) (
  // clock and control
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic        i2s,
  // samples
  input  wire logic [23:0] left,
  input  wire logic [23:0] right,
  // port pins
  output logic             sclk,
  output logic             lr,
  output logic             sdata
);
  int          ph = 0;
  logic [5:0]  bitIx = 6'h0;
  logic [31:0] slot;
  // frame of 128*HALF mclk stays far inside the rate limits
  always_ff @(posedge mclk)
  begin
    ph <= (!run || ph == HALF - 1) ? 0 : ph + 1;
    sclk <= run & (sclk ^ (ph == HALF - 1));
    if (run && ph == HALF - 1 && sclk)
      bitIx <= bitIx + 6'h1;
  end
  // left slot first, MSB one bit late in I2S; pad bits alternate
  assign lr = i2s ^ ~bitIx[5];
  assign slot = i2s ? {1'b0, bitIx[5] ? right : left, 7'h55}
                    : {bitIx[5] ? right : left, 8'h55};
  assign sdata = slot[5'h1f - bitIx[4:0]];
endmodule
`default_nettype wire

// file: test/asrc_serial_port_control_tb.sv
// self-checking bench of the serial port control block
// assumes the package and design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module asrc_serial_port_control_tb;
  import asrc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rxRun = 1'b0;
  logic servoFast = 1'b0;
  logic txI2s = 1'b0;
  logic pickRx = 1'b0;
  logic pickLr = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [WORD_W-1:0] srcLeft = 24'h0;
  logic [WORD_W-1:0] srcRight = 24'h0;
  int errors = 0;
  int checkCount = 0;
  wire [31:0] rdata;
  wire [2:0] bufClrAddr;
  wire rxSclkDrive, rxClkOe, rxLrDrive, txSclkDrive, txClkOe, txLrDrive;
  wire output_serial_data, muteOut, outPinsOe, bufClrWe, probe;
  wire srcSclk, srcLr, srcData, dspSclk, dspLr, dspData;
  wire rxSclkPin, rxLrPin, txSclkPin, txLrPin;
  // a clock pin follows whichever party is master
  assign rxSclkPin = rxClkOe ? rxSclkDrive : srcSclk;
  assign rxLrPin = rxClkOe ? rxLrDrive : srcLr;
  assign txSclkPin = txClkOe ? txSclkDrive : dspSclk;
  assign txLrPin = txClkOe ? txLrDrive : dspLr;
  assign probe = pickLr ? (pickRx ? rxLrDrive : txLrDrive) : (pickRx ? rxSclkDrive : txSclkDrive);

  asrc_serial_port_control #(.DEPTH(8)) dut_u (
    .mclk, .rst_n, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata,
    .rxSclkPin, .rxSclkDrive, .rxClkOe, .rxLrPin, .rxLrDrive, .rxSdataPin(srcData),
    .txSclkPin, .txSclkDrive, .txClkOe, .txLrPin, .txLrDrive, .tdmInPin(dspData),
    .output_serial_data, .muteOut, .outPinsOe, .servoFast, .srcLeft, .srcRight,
    .attenLeft(), .attenRight(), .attenValid(), .bufClrAddr, .bufClrWe);
  audio_source_model #(.HALF(4)) src_u (.mclk, .run(rxRun), .i2s(1'b0), .left(srcRight),
    .right(srcLeft), .sclk(srcSclk), .lr(srcLr), .sdata(srcData));
  audio_source_model #(.HALF(8)) dsp_u (.mclk, .run(rxRun), .i2s(txI2s), .left(srcLeft),
    .right(srcRight), .sclk(dspSclk), .lr(dspLr), .sdata(dspData));

  initial
    forever #2 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic regRead(input logic [3:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  // mute counter read a fixed distance after an input frame start
  task automatic muteStep(output logic [11:0] c);
    logic [31:0] st;
    @(posedge mclk iff rxLrPin === 1'b0);
    @(posedge mclk iff rxLrPin === 1'b1);
    repeat (20) @(posedge mclk);
    regRead(ADDR_STAT, st);
    c = st[13:2];
  endtask

  task automatic measure(output int n);
    logic s;
    s = probe;
    while (probe === s) @(posedge mclk);
    s = probe;
    n = 0;
    while (probe === s)
    begin
      @(posedge mclk);
      n++;
    end
  endtask

  // skips a frame so the slot holds the current samples
  task automatic grab(input logic lvl, output logic [31:0] got);
    repeat (2)
    begin
      @(posedge mclk iff txLrPin !== lvl);
      @(posedge mclk iff txLrPin === lvl);
    end
    for (int i = 0; i < 32; i++)
    begin
      @(posedge mclk iff txSclkPin === 1'b0);
      @(posedge mclk iff txSclkPin === 1'b1);
      got = {got[30:0], output_serial_data};
    end
  endtask

  function automatic logic [31:0] ratioOf(int m);
    return m % 4 == 1 ? 768 : m % 4 == 2 ? 512 : 256;
  endfunction

  function automatic logic [31:0] slotOf(int f, logic [23:0] w);
    return f == 1 ? {1'b0, w, 7'h0} : f == 3 ? {8'h0, w} : {w, 8'h0};
  endfunction

  task automatic summarize;
    $display("errors=%0d checks=%0d", errors, checkCount);
    if (errors == 0 && checkCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge mclk);
    errors++;
    summarize;
  end

  initial
  begin
    logic [31:0] v;
    logic [31:0] got;
    logic [11:0] a;
    logic [11:0] b;
    int n;
    void'($urandom(32'h836eed35));
    repeat (5) @(posedge mclk);
    chk({29'h0, outPinsOe, txClkOe, rxClkOe}, 32'h0);
    chk({31'h0, muteOut}, 32'h1);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({27'h0, outPinsOe, bufClrWe, bufClrAddr}, 32'h18);
    regRead(ADDR_STAT, v);
    chk({20'h0, v[13:2]}, 32'hfff);
    rxRun <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom;
      regWrite(ADDR_CTRL, v);
      regWrite(4'h8, ~v);
      regRead(ADDR_CTRL, got);
      chk(got, {20'h0, v[11:0]});
      regRead(4'h8, got);
      chk(got, 32'h0);
      regWrite(ADDR_CTRL, {29'h0, 3'(i)});
      regRead(ADDR_STAT, got);
      chk({31'h0, got[14]}, {31'h0, i == 2 || i == 3});
      regWrite(ADDR_CTRL, {22'h0, 3'(i), 7'h0});
      regRead(ADDR_STAT, got);
      chk({31'h0, got[15]}, {31'h0, i == 4});
    end
    regWrite(ADDR_CTRL, 32'h0);
    repeat (4000) @(posedge mclk);
    servoFast <= 1'b1;
    repeat (20) @(posedge mclk);
    servoFast <= 1'b0;
    repeat (20) @(posedge mclk);
    chk({31'h0, muteOut}, 32'h0);
    muteStep(a);
    repeat (8) muteStep(b);
    chk({20'h0, a - b}, 32'h8);
    regWrite(ADDR_CTRL, 32'h800);
    muteStep(a);
    repeat (8) muteStep(b);
    chk({20'h0, b - a}, 32'h8);
    for (int m = 0; m < 8; m++)
    begin
      regWrite(ADDR_CTRL, {22'h0, 3'(m), 7'h0});
      repeat (30) @(posedge mclk);
      chk({30'h0, rxClkOe, txClkOe}, {30'h0, m > 4, m inside {[1:3]}});
      if (m != 0 && m != 4)
      begin
        pickRx <= (m > 4);
        pickLr <= 1'b0;
        @(posedge mclk);
        measure(n);
        chk(32'(n), ratioOf(m) / 128);
        pickLr <= 1'b1;
        @(posedge mclk);
        measure(n);
        chk(32'(n), ratioOf(m) / 2);
      end
    end
    repeat (600) @(posedge mclk);
    chk({31'h0, muteOut}, 32'h1);
    // the last pass runs bypass: the source model carries srcRight as its left word
    for (int k = 0; k < 6; k++)
    begin
      srcLeft <= 24'($urandom);
      srcRight <= 24'($urandom);
      txI2s <= (k == 1);
      // mute stays requested while the settle flag is up
      regWrite(ADDR_CTRL, 32'h800 | (k == 5 ? 32'h400 : k == 4 ? 32'h60 : {27'h0, 2'(k), 3'h0}));
      grab(k != 1, got);
      chk(k == 4 ? got & 32'hffff : got, k == 4 ? 32'h0 : slotOf(k == 5 ? 0 : k, k == 5 ? srcRight : srcLeft));
    end
    summarize;
  end
endmodule
`default_nettype wire
